// ===== verilog/simd_bank_map.svh
// constants for the lane-parallel register bank: geometry, issue counts, state codes
`ifndef SIMD_BANK_MAP_SVH
`define SIMD_BANK_MAP_SVH
`define SB_NUM_DOUBLE 32
`define SB_NUM_QUAD 16
`define SB_DOUBLE_W 64
`define SB_QUAD_W 128
`define SB_LANES 16
`define SB_ISSUE_ONE 2'h1
`define SB_ISSUE_TWO 2'h2
`define SB_ST_IDLE 4'h1
`define SB_ST_READ 4'h2
`define SB_ST_EXEC 4'h4
`define SB_ST_WB 4'h8
`endif

// ===== verilog/simd_bank_pkg.sv
// types shared by the register bank and its storage
package simd_bank_pkg;
  `include "simd_bank_map.svh"
  typedef enum logic [3:0] {
    ST_IDLE = `SB_ST_IDLE,
    ST_READ = `SB_ST_READ,
    ST_EXEC = `SB_ST_EXEC,
    ST_WB = `SB_ST_WB
  } bank_state_t;
  typedef enum logic [2:0] {
    OP_ADD = 3'h0,
    OP_SUB = 3'h1,
    OP_MUL = 3'h2,  // vector_multiply_op
    OP_MLA = 3'h3,  // vector_multiply_accumulate_op
    OP_DIV = 3'h4,
    OP_SQRT = 3'h5
  } op_code_t;
  // element type: upper bits kind, lower bits width class for the three integer kinds
  typedef enum logic [3:0] {
    ET_U8 = 4'h0, ET_U16 = 4'h1, ET_U32 = 4'h2, ET_U64 = 4'h3,
    ET_S8 = 4'h4, ET_S16 = 4'h5, ET_S32 = 4'h6, ET_S64 = 4'h7,
    ET_I8 = 4'h8, ET_I16 = 4'h9, ET_I32 = 4'hA, ET_I64 = 4'hB,
    ET_F16 = 4'hC,  // half_float_element_type
    ET_F32 = 4'hD,
    ET_F64 = 4'hE,
    ET_P8 = 4'hF    // poly8_element_type
  } elem_type_t;
endpackage

// ===== verilog/bank_port_if.sv
// storage access bundle between the bank control and its storage
`timescale 1ns/100ps
interface bank_port_if;
  logic wr_en;
  logic wr_quad;
  logic [4:0] wr_idx;
  logic [127:0] wr_data;
  logic [2:0] rd_quad;
  logic [14:0] rd_idx;
  logic [383:0] rd_data;
  modport ctrl (output wr_en, wr_quad, wr_idx, wr_data, rd_quad, rd_idx, input rd_data);
  modport store (input wr_en, wr_quad, wr_idx, wr_data, rd_quad, rd_idx, output rd_data);
endinterface

// ===== verilog/simd_bank_store.sv
// shared 32 x 64-bit storage with quad and double views, three registered read ports
`timescale 1ns/100ps
module simd_bank_store
  import simd_bank_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_ce,
  bank_port_if.store bp
);
  logic [63:0] dbl_q [0:`SB_NUM_DOUBLE-1];
  logic [383:0] rd_q;

  // quad n writes doubles 2n (low) and 2n+1 (high)
  always_ff @(posedge i_mclk) begin
    if (i_ce && bp.wr_en) begin
      if (bp.wr_quad) begin
        dbl_q[{bp.wr_idx[3:0], 1'b0}] <= bp.wr_data[63:0];
        dbl_q[{bp.wr_idx[3:0], 1'b1}] <= bp.wr_data[127:64];
      end else begin
        dbl_q[bp.wr_idx] <= bp.wr_data[63:0];
      end
    end
  end

  // read data leave through a register; double view reads zero above bit 63
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_rd
      always_ff @(posedge i_mclk) begin
        if (i_ce) begin
          if (bp.rd_quad[p]) begin
            rd_q[p*128 +: 128] <= {dbl_q[{bp.rd_idx[p*5 +: 4], 1'b1}],
                                   dbl_q[{bp.rd_idx[p*5 +: 4], 1'b0}]};
          end else begin
            rd_q[p*128 +: 128] <= {64'h0, dbl_q[bp.rd_idx[p*5 +: 5]]};
          end
        end
      end
    end
  endgenerate
  assign bp.rd_data = rd_q;
endmodule

// ===== verilog/simd_bank.sv
// lane-parallel register bank: access port, operation sequencer and lane datapath
`timescale 1ns/100ps
// Function
// - bank reads and writes as sixteen 128-bit or thirty-two 64-bit registers.
// - a quad occupies exactly two doubles; writes through one view show in other.
// - scalar and vector operations share the same thirty-two 64-bit doubles.
// - saving and restoring all doubles captures the full vector context.
// - one vector operation applies the same operation to every packed element.
// - add and subtract carries never cross element boundaries; multiply-accumulate adds in 64-bit halves or one 128-bit sum.
// - element types cover 8..64-bit integers, 16/32/64-bit float and 8-bit polynomial.
// - float is refused at every precision, vector and scalar alike.
// - divide exists only as a scalar operation; square root is refused in both.
// - quad vector multiply or multiply-accumulate issues in two cycles.
// - scalar double multiply-accumulate occupies two issue cycles.
// - issue counts are minima; dependent operands wait for earlier writeback.
module simd_bank
  import simd_bank_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_acc_wr,
  input wire logic i_acc_rd,
  input wire logic i_acc_quad,
  input wire logic [4:0] i_acc_idx,
  input wire logic [127:0] i_acc_wdata,
  output logic [127:0] o_acc_rdata,
  output logic o_acc_rvalid,
  input wire logic i_op_valid,
  input wire op_code_t i_op_code,
  input wire elem_type_t i_op_type,
  input wire logic i_op_vector,
  input wire logic i_op_quad,
  input wire logic [4:0] i_op_dst,
  input wire logic [4:0] i_op_srca,
  input wire logic [4:0] i_op_srcb,
  output logic o_op_ready,
  output logic o_op_done,
  output logic o_op_err
);
  typedef struct packed {
    bank_state_t st;
    op_code_t code;
    elem_type_t etype;
    logic vec;
    logic quad;
    logic [4:0] dst;
    logic [4:0] srca;
    logic [4:0] srcb;
    logic [1:0] cnt;
    logic err;
    logic acc_pend;
    logic [127:0] acc_rdata;
    logic acc_rvalid;
    logic ready;
    logic done;
    logic op_err;
  } bank_reg_t;

  bank_reg_t r_q, r_d;
  bank_port_if bp ();
  logic [127:0] opa, opb, opc, res;
  logic [63:0] sc_res;
  logic [1:0] issue_cnt;
  logic bad_op;
  logic [3:0] eb; // element size in bytes minus one, as a byte mask
  logic [16:0] carry;
  logic [127:0] sum, prod;

  simd_bank_store u_store (
    .i_mclk(i_mclk),
    .i_ce(i_ce),
    .bp(bp)
  );

  assign opa = bp.rd_data[127:0];
  assign opb = bp.rd_data[255:128];
  assign opc = bp.rd_data[383:256];

  // minimum issue occupancy from shape, operation and precision
  always_comb begin
    issue_cnt = `SB_ISSUE_ONE;
    if (i_op_vector && i_op_quad) begin
      issue_cnt = `SB_ISSUE_TWO;
    end else if (!i_op_vector && i_op_type == ET_F64 &&
                 (i_op_code == OP_MUL || i_op_code == OP_MLA)) begin
      issue_cnt = `SB_ISSUE_TWO;
    end
  end

  // vector float double, vector divide/root, half-float arithmetic and scalar square root are refused
  always_comb begin
    bad_op = 1'b0;
    if (i_op_vector && i_op_type == ET_F64) begin
      bad_op = 1'b1;
    end
    if (i_op_vector && (i_op_code == OP_DIV || i_op_code == OP_SQRT)) begin
      bad_op = 1'b1;
    end
    if (i_op_type == ET_F16 || i_op_code == OP_SQRT) begin
      bad_op = 1'b1;
    end
  end

  // width class of the element; scalar work always uses one 64-bit lane
  always_comb begin
    case (r_q.etype[1:0])
      2'h0: eb = 4'h0;
      2'h1: eb = 4'h1;
      2'h2: eb = 4'h3;
      default: eb = 4'h7;
    endcase
    if (r_q.etype == ET_P8) begin
      eb = 4'h0;
    end
    if (r_q.etype == ET_F32) begin
      eb = 4'h3;
    end
    if (!r_q.vec || r_q.etype == ET_F64) begin
      eb = 4'h7;
    end
  end

  // per-byte lane: the carry chain is cut at every element boundary
  assign carry[0] = (r_q.code == OP_SUB);
  genvar i;
  generate
    for (i = 0; i < `SB_LANES; i++) begin : g_lane
      logic [8:0] s;
      logic [7:0] bsel;
      logic [7:0] pm;
      logic [15:0] p16;
      logic [31:0] p32;
      logic [63:0] p64;
      logic [7:0] pp;
      logic [7:0] mul_lo;
      assign bsel = (r_q.code == OP_SUB) ? ~opb[i*8 +: 8] : opb[i*8 +: 8];
      assign s = {1'b0, opa[i*8 +: 8]} + {1'b0, bsel} + {8'h00, carry[i]};
      assign sum[i*8 +: 8] = s[7:0];
      if (i < `SB_LANES - 1) begin : g_cut
        assign carry[i+1] = (((i + 1) & eb) == 0) ? (r_q.code == OP_SUB) : s[8];
      end else begin : g_end
        assign carry[i+1] = s[8];
      end
      // products per element width; a lane keeps the byte that falls on it
      if (i % 8 == 0) begin : g_m64
        assign p64 = opa[i*8 +: 64] * opb[i*8 +: 64];
      end else begin : g_n64
        assign p64 = 64'h0;
      end
      if (i % 4 == 0) begin : g_m32
        assign p32 = opa[i*8 +: 32] * opb[i*8 +: 32];
      end else begin : g_n32
        assign p32 = 32'h0;
      end
      if (i % 2 == 0) begin : g_m16
        assign p16 = opa[i*8 +: 16] * opb[i*8 +: 16];
      end else begin : g_n16
        assign p16 = 16'h0;
      end
      assign pm = opa[i*8 +: 8] * opb[i*8 +: 8];
      // carry-less byte product over GF(2), low eight bits
      always_comb begin
        pp = 8'h00;
        for (int k = 0; k < 8; k++) begin
          if (opb[i*8 + k]) begin
            pp = pp ^ (opa[i*8 +: 8] << k);
          end
        end
      end
      always_comb begin
        case (eb)
          4'h0: mul_lo = (r_q.etype == ET_P8) ? pp : pm;
          4'h1: mul_lo = g_lane[i - (i % 2)].p16[(i % 2)*8 +: 8];
          4'h3: mul_lo = g_lane[i - (i % 4)].p32[(i % 4)*8 +: 8];
          default: mul_lo = g_lane[i - (i % 8)].p64[(i % 8)*8 +: 8];
        endcase
      end
      assign prod[i*8 +: 8] = mul_lo;
    end
  endgenerate

  // scalar divide; a zero divisor yields all ones
  assign sc_res = (opb[63:0] == 64'h0) ? 64'hFFFF_FFFF_FFFF_FFFF : opa[63:0] / opb[63:0];

  // float operands run on the integer lanes only as bit patterns, so they flag an error
  always_comb begin
    case (r_q.code)
      OP_ADD: res = sum;
      OP_SUB: res = sum;
      OP_MUL: res = prod;
      OP_MLA: res = prod + opc; // one 128-bit add for 64-bit lanes; narrower lanes add in 64-bit halves below
      OP_DIV: res = {64'h0, sc_res};
      default: res = opa;
    endcase
    if (r_q.code == OP_MLA && eb != 4'h7) begin
      res = {opc[127:64] + prod[127:64], opc[63:0] + prod[63:0]};
    end
  end

  // storage drive: access port while idle, operands in read, result in writeback
  always_comb begin
    bp.wr_en = 1'b0;
    bp.wr_quad = 1'b0;
    bp.wr_idx = 5'h00;
    bp.wr_data = 128'h0;
    bp.rd_quad = 3'h0;
    bp.rd_idx = 15'h0000;
    if (r_q.st == ST_WB) begin
      bp.wr_en = !r_q.err;
      bp.wr_quad = r_q.vec && r_q.quad;
      bp.wr_idx = r_q.dst;
      bp.wr_data = res;
    end
    // operand indices stay put until writeback: the storage re-registers every cycle
    if (r_q.st != ST_IDLE) begin
      bp.rd_quad = {3{r_q.vec && r_q.quad}};
      bp.rd_idx = {r_q.dst, r_q.srcb, r_q.srca};
    end else begin
      bp.wr_en = i_acc_wr;
      bp.wr_quad = i_acc_quad;
      bp.wr_idx = i_acc_idx;
      bp.wr_data = i_acc_wdata;
      bp.rd_quad = {i_acc_quad, 2'h0};
      bp.rd_idx = {i_acc_idx, 10'h000};
    end
  end

  // sequencer: one operation in flight, so a dependent source always sees the writeback
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    r_d.acc_rvalid = 1'b0;
    r_d.acc_pend = 1'b0;
    if (r_q.acc_pend) begin
      r_d.acc_rdata = opc;
      r_d.acc_rvalid = 1'b1;
    end
    case (r_q.st)
      ST_IDLE: begin
        r_d.acc_pend = i_acc_rd;
        if (i_op_valid) begin
          r_d.st = ST_READ;
          r_d.code = i_op_code;
          r_d.etype = i_op_type;
          r_d.vec = i_op_vector;
          r_d.quad = i_op_quad;
          r_d.dst = i_op_dst;
          r_d.srca = i_op_srca;
          r_d.srcb = i_op_srcb;
          r_d.cnt = issue_cnt;
          r_d.err = bad_op || (i_op_type == ET_F32) || (i_op_type == ET_F64);
        end
      end
      ST_READ: r_d.st = ST_EXEC;
      ST_EXEC: begin
        r_d.cnt = r_q.cnt - 2'h1;
        if (r_q.cnt == `SB_ISSUE_ONE) begin
          r_d.st = ST_WB;
        end
      end
      ST_WB: begin
        r_d.st = ST_IDLE;
        r_d.done = 1'b1;
        r_d.op_err = r_q.err;
      end
      default: r_d.st = ST_IDLE;
    endcase
    r_d.ready = (r_d.st == ST_IDLE);
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      r_q <= '{st: ST_IDLE, code: OP_ADD, etype: ET_U8, ready: 1'b1, default: '0};
    end else if (i_ce) begin
      r_q <= r_d;
    end
  end

  assign o_acc_rdata = r_q.acc_rdata;
  assign o_acc_rvalid = r_q.acc_rvalid;
  assign o_op_ready = r_q.ready;
  assign o_op_done = r_q.done;
  assign o_op_err = r_q.op_err;

  // checks
  int unsigned busy_cnt;
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      busy_cnt <= 0;
    end else if (i_ce) begin
      busy_cnt <= (r_q.st == ST_IDLE) ? 0 : busy_cnt + 1;
    end
  end
  property p_quad_two;
    @(posedge i_mclk) disable iff (i_reset)
    (i_ce && r_q.st == ST_IDLE && i_op_valid && i_op_vector && i_op_quad) |=>
      (r_q.cnt == 2'h2);
  endproperty
  a_quad_two: assert property (p_quad_two) else $error("quad op not two issue cycles");
  property p_dmla_two;
    @(posedge i_mclk) disable iff (i_reset)
    (i_ce && r_q.st == ST_IDLE && i_op_valid && !i_op_vector && i_op_type == ET_F64 &&
     i_op_code == OP_MLA) |=> (r_q.cnt == 2'h2);
  endproperty
  a_dmla_two: assert property (p_dmla_two) else $error("scalar double mla not two");
  property p_busy_bound;
    @(posedge i_mclk) disable iff (i_reset) busy_cnt <= 4;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("operation held too long");
  property p_wb_ready;
    @(posedge i_mclk) disable iff (i_reset)
    (i_ce && r_q.st == ST_WB) |=> (o_op_done && o_op_ready);
  endproperty
  a_wb_ready: assert property (p_wb_ready) else $error("done without ready");
  property p_vec_f64;
    @(posedge i_mclk) disable iff (i_reset)
    (r_q.st == ST_WB && r_q.vec && r_q.etype == ET_F64) |-> !bp.wr_en;
  endproperty
  a_vec_f64: assert property (p_vec_f64) else $error("vector double float written");
  property p_vec_div;
    @(posedge i_mclk) disable iff (i_reset)
    (r_q.st == ST_WB && r_q.vec && r_q.code == OP_DIV) |-> !bp.wr_en;
  endproperty
  a_vec_div: assert property (p_vec_div) else $error("vector divide written");
  property p_byte_iso;
    @(posedge i_mclk) disable iff (i_reset)
    (r_q.st == ST_WB && r_q.vec && eb == 4'h0 && r_q.code == OP_ADD) |->
      (res[15:8] == opa[15:8] + opb[15:8]);
  endproperty
  a_byte_iso: assert property (p_byte_iso) else $error("carry crossed byte lane");
  property p_acc_rd;
    @(posedge i_mclk) disable iff (i_reset)
    (i_ce && r_q.st == ST_IDLE && i_acc_rd) ##1 i_ce |=> o_acc_rvalid;
  endproperty
  a_acc_rd: assert property (p_acc_rd) else $error("access read not answered");
  property p_quad_wr;
    @(posedge i_mclk) disable iff (i_reset)
    (r_q.st == ST_WB && bp.wr_en) |-> (bp.wr_quad == (r_q.vec && r_q.quad));
  endproperty
  a_quad_wr: assert property (p_quad_wr) else $error("writeback view wrong");
  c_quad_mla: cover property (@(posedge i_mclk) disable iff (i_reset)
    r_q.st == ST_WB && r_q.vec && r_q.quad && r_q.code == OP_MLA);
  c_poly: cover property (@(posedge i_mclk) disable iff (i_reset)
    r_q.st == ST_WB && r_q.etype == ET_P8);
  c_acc: cover property (@(posedge i_mclk) disable iff (i_reset) o_acc_rvalid);
endmodule

// ===== test/issue_model.sv
// core-side issue model: holds one operation request until the bank takes it
`timescale 1ns/100ps
module issue_model (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_go,
  input wire logic [23:0] i_cmd,
  input wire logic i_ready,
  output logic o_valid,
  output logic [23:0] o_cmd
);
  logic [23:0] cmd_q;
  // idle fields show inverted junk so a bank that latches late sees garbage
  assign o_cmd = o_valid ? cmd_q : ~cmd_q;
  // request stands until an edge with ready high; only one op is ever in flight
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_valid <= 1'b0;
      cmd_q <= 24'h0;
    end else if (o_valid && i_ready) begin
      o_valid <= 1'b0;
    end else if (i_go && !o_valid) begin
      o_valid <= 1'b1;
      cmd_q <= i_cmd;
    end
  end
endmodule

// ===== test/tb_simd_bank.sv
// self-checking bench for the lane-parallel register bank
`timescale 1ns/100ps
module tb_simd_bank;
  import simd_bank_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic acc_wr = 1'b0, acc_rd = 1'b0, acc_quad = 1'b0, go = 1'b0;
  logic [4:0] acc_idx = 5'h00;
  logic [127:0] acc_wdata = 128'h0, o_acc_rdata;
  logic o_acc_rvalid, o_op_ready, o_op_done, o_op_err, op_valid;
  logic [23:0] cmd = 24'h0, op_cmd;
  logic [63:0] m [32];
  logic [15:0] lf = 16'h6D9B;
  int fails = 0, tests_run = 0;
  // free-running clock
  always #5 i_mclk = ~i_mclk;
  simd_bank dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(1'b1), .i_acc_wr(acc_wr),
    .i_acc_rd(acc_rd), .i_acc_quad(acc_quad), .i_acc_idx(acc_idx), .i_acc_wdata(acc_wdata),
    .o_acc_rdata(o_acc_rdata), .o_acc_rvalid(o_acc_rvalid), .i_op_valid(op_valid),
    .i_op_code(op_code_t'(op_cmd[23:21])), .i_op_type(elem_type_t'(op_cmd[20:17])),
    .i_op_vector(op_cmd[16]), .i_op_quad(op_cmd[15]), .i_op_dst(op_cmd[14:10]),
    .i_op_srca(op_cmd[9:5]), .i_op_srcb(op_cmd[4:0]), .o_op_ready(o_op_ready),
    .o_op_done(o_op_done), .o_op_err(o_op_err));
  issue_model core (.i_mclk(i_mclk), .i_reset(i_reset), .i_go(go), .i_cmd(cmd),
    .i_ready(o_op_ready), .o_valid(op_valid), .o_cmd(op_cmd));

  task automatic chk(logic [127:0] got, logic [127:0] exp, string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // 16-bit lfsr, four steps per 64-bit word
  task automatic rnd(output logic [63:0] v);
    v = 64'h0;
    repeat (4) begin
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      v = {v[47:0], lf};
    end
  endtask
  // reference lane arithmetic; carries are masked per lane so none can leak
  function automatic logic [63:0] f(op_code_t c, int w, logic [63:0] a, logic [63:0] b);
    logic [63:0] mk, r, x, y;
    r = 64'h0;
    mk = (w == 64) ? '1 : (64'h1 << w) - 64'h1;
    if (c == OP_DIV) return (b == 64'h0) ? '1 : a / b;
    for (int i = 0; i < 64; i += w) begin
      x = (a >> i) & mk;
      y = (b >> i) & mk;
      r = r | (((c == OP_ADD) ? x + y : (c == OP_SUB) ? x - y : x * y) & mk) << i;
    end
    return r;
  endfunction
  task automatic wr(logic q, logic [4:0] i, logic [127:0] d);
    @(negedge i_mclk);
    acc_wr = 1'b1;
    acc_quad = q;
    acc_idx = i;
    acc_wdata = d;
    @(negedge i_mclk);
    acc_wr = 1'b0;
    acc_wdata = ~d;
    if (q) begin
      m[{i[3:0], 1'b0}] = d[63:0];
      m[{i[3:0], 1'b1}] = d[127:64];
    end else begin
      m[i] = d[63:0];
    end
  endtask
  // read answer must arrive one edge after the taking edge
  task automatic rd(logic q, logic [4:0] i, output logic [127:0] d);
    int n;
    @(negedge i_mclk);
    acc_rd = 1'b1;
    acc_quad = q;
    acc_idx = i;
    @(negedge i_mclk);
    acc_rd = 1'b0;
    acc_idx = ~i;
    n = 1;
    while (o_acc_rvalid !== 1'b1 && n < 8) begin
      @(negedge i_mclk);
      n++;
    end
    chk(128'(n), 128'(2), "read latency");
    d = o_acc_rdata;
  endtask
  // one operation through the core model, then the destination is read back
  task automatic op(op_code_t c, elem_type_t t, logic v, logic q, logic [4:0] dd,
                    logic [4:0] a, logic [4:0] b);
    logic e;
    int nn, n, w;
    logic [63:0] r0, r1;
    logic [127:0] g;
    e = t == ET_F16 || t == ET_F32 || t == ET_F64 || c == OP_SQRT || (v && c == OP_DIV);
    nn = ((v && q) || (!v && t == ET_F64 && (c == OP_MUL || c == OP_MLA))) ? 2 : 1;
    w = v ? 8 << t[1:0] : 64;
    @(negedge i_mclk);
    cmd = {c, t, v, q, dd, a, b};
    go = 1'b1;
    @(negedge i_mclk);
    go = 1'b0;
    n = 1;
    while (o_op_done !== 1'b1 && n < 12) begin
      @(negedge i_mclk);
      n++;
    end
    chk(128'(n), 128'(nn + 4), "op latency");
    chk(128'(o_op_err), 128'(e), "op refusal");
    if (v && q) begin
      r0 = f(c, w, m[{a[3:0], 1'b0}], m[{b[3:0], 1'b0}]);
      r1 = f(c, w, m[{a[3:0], 1'b1}], m[{b[3:0], 1'b1}]);
      if (!e) m[{dd[3:0], 1'b0}] = r0;
      if (!e) m[{dd[3:0], 1'b1}] = r1;
      rd(1'b1, dd, g);
      chk(g, {m[{dd[3:0], 1'b1}], m[{dd[3:0], 1'b0}]}, "quad result");
    end else begin
      r0 = f(c, w, m[a], m[b]);
      if (!e) m[dd] = r0;
      rd(1'b0, dd, g);
      chk(g, {64'h0, m[dd]}, "double result");
    end
  endtask

  // watchdog sized far beyond the fewer than a thousand cycles the sequence needs
  initial begin
    #200000;
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end
  // main sequence
  initial begin
    logic [127:0] g;
    logic [63:0] v0, v1;
    repeat (6) @(posedge i_mclk);
    #2;
    chk({o_op_ready, o_op_done, o_op_err, o_acc_rvalid}, 128'h8, "reset flags");
    chk(o_acc_rdata, 128'h0, "reset read data");
    @(negedge i_mclk);
    i_reset = 1'b0;
    for (int i = 0; i < 32; i++) begin
      rnd(v0);
      wr(1'b0, 5'(i), {~v0, v0});
    end
    for (int i = 0; i < 32; i++) begin
      rd(1'b0, 5'(i), g);
      chk(g, {64'h0, m[i]}, "context save");
    end
    for (int i = 0; i < 16; i++) begin
      rd(1'b1, 5'(i), g);
      chk(g, {m[2 * i + 1], m[2 * i]}, "quad alias");
    end
    rnd(v0);
    rnd(v1);
    wr(1'b1, 5'h07, {v1, v0});
    rd(1'b0, 5'h0E, g);
    chk(g, {64'h0, v0}, "quad low half");
    rd(1'b0, 5'h0F, g);
    chk(g, {64'h0, v1}, "quad high half");
    // every byte overflows so any carry between lanes shows
    wr(1'b1, 5'h02, {128{1'b1}});
    wr(1'b1, 5'h03, {16{8'h01}});
    op(OP_ADD, ET_U8, 1'b1, 1'b1, 5'h01, 5'h02, 5'h03);
    op(OP_SUB, ET_S16, 1'b1, 1'b1, 5'h04, 5'h03, 5'h02);
    for (int c = 0; c < 3; c++) begin
      for (int t = 0; t < 12; t++) begin
        op(op_code_t'(c), elem_type_t'(t), 1'b1, 1'b0, 5'(16 + t), 5'(t), 5'(31 - t));
      end
    end
    op(OP_MUL, ET_F32, 1'b1, 1'b1, 5'h05, 5'h06, 5'h07);
    op(OP_MLA, ET_F32, 1'b1, 1'b1, 5'h05, 5'h06, 5'h07);
    op(OP_MLA, ET_F64, 1'b0, 1'b0, 5'h09, 5'h0A, 5'h0B);
    op(OP_MUL, ET_F64, 1'b0, 1'b0, 5'h09, 5'h0A, 5'h0B);
    op(OP_ADD, ET_F64, 1'b1, 1'b0, 5'h09, 5'h0A, 5'h0B);
    op(OP_ADD, ET_F16, 1'b1, 1'b0, 5'h09, 5'h0A, 5'h0B);
    op(OP_DIV, ET_U32, 1'b1, 1'b0, 5'h09, 5'h0A, 5'h0B);
    op(OP_SQRT, ET_F32, 1'b1, 1'b0, 5'h09, 5'h0A, 5'h0B);
    op(OP_DIV, ET_U64, 1'b0, 1'b0, 5'h0C, 5'h0D, 5'h0E);
    wr(1'b0, 5'h15, 128'h0);
    op(OP_DIV, ET_U64, 1'b0, 1'b0, 5'h0C, 5'h0D, 5'h15);
    // scalar result feeds straight into the next op on shared storage
    op(OP_ADD, ET_U64, 1'b0, 1'b0, 5'h08, 5'h0C, 5'h08);
    op(OP_ADD, ET_U32, 1'b1, 1'b1, 5'h04, 5'h04, 5'h01);
    wrap_up();
  end
endmodule
